/* File: dual_port_io.sv */
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module dual_port_io #(
  parameter logic [3:0] PULLUP_MASK_OPTION = 4'hf,
  parameter logic [3:0] PULLDOWN_MASK_OPTION = 4'hf
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Prescaler taps and counter PWM.
  input wire logic [16:1] ck_taps,
  input wire logic pwm_in,
  // Input port.
  input wire logic [3:0] input_pins,
  output logic [3:0] input_pull_enable,
  output logic [3:0] input_irq_flag,
  output logic no_input_reset,
  // Bidirectional port.
  input wire logic [3:0] bidir_pins_in,
  output logic [3:0] bidir_pins_out,
  output logic [3:0] bidir_pins_oe,
  output logic [3:0] bidir_pullup_en,
  output logic [3:0] bidir_pulldown_en,
  // Shared measurement block.
  input wire logic compare_below,
  output logic comparator_select_bit,
  output logic measure_active,
  output logic comparator_irq
);
  import dual_port_io_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  logic [7:0] addr_reg; // Latched address of the data phase.
  logic wr_pend_reg; // A write data phase is in progress.
  logic rd_pend_reg; // A read data phase is in progress.
  logic rd_wait_reg; // First cycle of a read, which waits.
  logic [31:0] rd_mux; // Read value selected by the address.
  logic [31:0] hrdata_reg; // Registered read data.
  logic accept; // Address phase taken this edge.
  logic [31:0] wdata; // Write data of the committing write.

  assign accept = hsel & hready & htrans[1];
  assign wdata = hwdata;

  // Latch the address phase; reads insert one wait cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= 8'h00;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
    end else begin
      if (hreadyout) begin
        wr_pend_reg <= accept & hwrite;
        rd_pend_reg <= accept & ~hwrite;
        rd_wait_reg <= accept & ~hwrite;
        if (accept) begin
          addr_reg <= {haddr[7:2], 2'b00};
        end
      end else begin
        rd_wait_reg <= 1'b0;
      end
    end
  end

  // A write commits at the end of its data phase.
  logic wr_commit;
  assign wr_commit = wr_pend_reg;

  // Write strobe per register.
  function automatic logic wr_to(input logic [7:0] ofs);
    return wr_commit && (addr_reg == ofs);
  endfunction

  assign hreadyout = ~rd_wait_reg;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // Load the read word during the wait cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_wait_reg) begin
      hrdata_reg <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers.

  logic [3:0] input_irq_mask_reg; // One enables the pin request.
  logic [3:0] input_edge_reg; // One selects the falling edge.
  logic [3:0] input_deb_off_reg; // One bypasses the debouncer.
  logic [3:0] input_pull_off_reg; // One removes the pull resistor.
  logic [3:0] bidir_dir_reg; // One makes the pin an output.
  logic [3:0] bidir_data_reg; // Output data latches.
  logic [3:0] bidir_pd_off_reg; // One removes the pull-down.
  logic [3:0] bidir_od_reg; // One selects open drain.
  logic [3:0] tap_option_reg; // Tap routing and input reset option.
  logic [1:0] presc_ctrl_reg; // PWM route and debounce clock choice.
  logic [1:0] comp_ctrl_reg; // Comparator select and enable.
  logic comp_irq_mask_reg; // One enables the comparator request.

  // Plain read/write registers, all cleared by reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_irq_mask_reg <= RST_NIBBLE;
      input_edge_reg <= RST_NIBBLE;
      input_deb_off_reg <= RST_NIBBLE;
      input_pull_off_reg <= RST_NIBBLE;
      bidir_dir_reg <= RST_NIBBLE;
      bidir_data_reg <= RST_NIBBLE;
      bidir_pd_off_reg <= RST_NIBBLE;
      bidir_od_reg <= RST_NIBBLE;
      tap_option_reg <= RST_NIBBLE;
      presc_ctrl_reg <= 2'b00;
      comp_ctrl_reg <= 2'b00;
      comp_irq_mask_reg <= 1'b0;
    end else begin
      if (wr_to(OFS_INPUT_IRQ_MASK)) input_irq_mask_reg <= wdata[3:0];
      if (wr_to(OFS_INPUT_EDGE)) input_edge_reg <= wdata[3:0];
      if (wr_to(OFS_INPUT_DEB_OFF)) input_deb_off_reg <= wdata[3:0];
      if (wr_to(OFS_INPUT_PULL_OFF)) input_pull_off_reg <= wdata[3:0];
      if (wr_to(OFS_BIDIR_DIR)) bidir_dir_reg <= wdata[3:0];
      if (wr_to(OFS_BIDIR_DATA)) bidir_data_reg <= wdata[3:0];
      if (wr_to(OFS_BIDIR_PD_OFF)) bidir_pd_off_reg <= wdata[3:0];
      if (wr_to(OFS_BIDIR_OD)) bidir_od_reg <= wdata[3:0];
      if (wr_to(OFS_TAP_OPTION)) tap_option_reg <= wdata[3:0];
      if (wr_to(OFS_PRESC_CTRL)) presc_ctrl_reg <= wdata[1:0];
      if (wr_to(OFS_COMP_CTRL)) comp_ctrl_reg <= wdata[1:0];
      if (wr_to(OFS_COMP_IRQ)) comp_irq_mask_reg <= wdata[COMP_IRQ_MASK_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Prescaler tap edges.

  logic [16:1] tap_prev_reg; // Taps one cycle ago.
  logic [16:1] tap_rise; // One-cycle enable on each tap rising edge.

  // Rising edges of the taps act as slow clock enables.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tap_prev_reg <= '0;
    end else begin
      tap_prev_reg <= ck_taps;
    end
  end
  assign tap_rise = ck_taps & ~tap_prev_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Input port debounce and interrupt flags.

  logic deb_tick; // Rising edge of the chosen debounce clock.
  logic [3:0] deb_sample_reg; // Level seen at the last debounce edge.
  logic [3:0] deb_level_reg; // Accepted debounced level.
  logic [3:0] irq_src; // Level feeding edge detection.
  logic [3:0] irq_src_prev_reg; // That level one cycle ago.
  logic [3:0] active_edge; // Selected edge seen this cycle.
  logic [3:0] input_flag_reg; // Sticky pin requests.

  assign deb_tick = presc_ctrl_reg[PRESC_DEB_SEL_BIT] ? tap_rise[CK_DEB_FAST]
                                                       : tap_rise[CK_DEB_SLOW];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_input_bit
      // Accept a level only when two debounce edges see the same value.
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          deb_sample_reg[gi] <= 1'b0;
          deb_level_reg[gi] <= 1'b0;
        end else if (deb_tick) begin
          deb_sample_reg[gi] <= input_pins[gi];
          if (deb_sample_reg[gi] == input_pins[gi]) begin
            deb_level_reg[gi] <= input_pins[gi];
          end
        end
      end

      // Direct or debounced source, then the selected edge.
      assign irq_src[gi] = input_deb_off_reg[gi] ? input_pins[gi]
                                                 : deb_level_reg[gi];
      assign active_edge[gi] = input_edge_reg[gi]
                               ? (irq_src_prev_reg[gi] & ~irq_src[gi])
                               : (~irq_src_prev_reg[gi] & irq_src[gi]);

      // A new edge wins over a clearing write in the same cycle.
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          irq_src_prev_reg[gi] <= 1'b0;
          input_flag_reg[gi] <= 1'b0;
        end else begin
          irq_src_prev_reg[gi] <= irq_src[gi];
          if (input_irq_mask_reg[gi] && active_edge[gi]) begin
            input_flag_reg[gi] <= 1'b1;
          end else if (wr_to(OFS_INPUT_IRQ_FLAGS) && wdata[gi]) begin
            input_flag_reg[gi] <= 1'b0;
          end
        end
      end

      // Input pull resistor stays on unless disabled.
      assign input_pull_enable[gi] = ~input_pull_off_reg[gi];
    end
  endgenerate

  assign input_irq_flag = input_flag_reg;
  assign no_input_reset = tap_option_reg[TAP_NO_INPUT_RESET];

  ////////////////////////////////////////////////////////////////////////////////
  // Bidirectional port drivers and pulls.

  logic [3:0] route_en; // A tap or PWM owns the pin's value.
  logic [3:0] route_val; // The routed signal per pin.
  logic [3:0] drive_val; // Value the pin should show.

  assign route_en = {presc_ctrl_reg[PRESC_PWM_BIT], tap_option_reg[TAP_SLOW_BIT],
                     tap_option_reg[TAP_MID_BIT], tap_option_reg[TAP_FAST_BIT]};
  assign route_val = {pwm_in, ck_taps[CK_SLOW], ck_taps[CK_MID], ck_taps[CK_FAST]};

  generate
    for (gi = 0; gi < 4; gi++) begin : g_bidir_bit
      assign drive_val[gi] = route_en[gi] ? route_val[gi] : bidir_data_reg[gi];
      assign bidir_pins_out[gi] = drive_val[gi];
      // Input mode floats; open drain drives only low.
      assign bidir_pins_oe[gi] = bidir_dir_reg[gi]
                                 & (~bidir_od_reg[gi] | ~drive_val[gi]);
      assign bidir_pulldown_en[gi] = PULLDOWN_MASK_OPTION[gi] & ~bidir_pd_off_reg[gi]
                                     & ~bidir_od_reg[gi];
      assign bidir_pullup_en[gi] = PULLUP_MASK_OPTION[gi] & bidir_od_reg[gi]
                                   & (~bidir_dir_reg[gi] | drive_val[gi]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Comparator sequencer.

  cmp_state_e cmp_state_reg; // Sequencer state.
  logic [1:0] gap_cnt_reg; // Idle measurement periods left.
  logic comp_result_reg; // Last result, one when below threshold.
  logic first_done_reg; // A result exists since enabling.
  logic comp_flag_reg; // Sticky comparator request.
  logic meas_end; // Measurement completes this cycle.

  assign meas_end = (cmp_state_reg == CMP_MEAS) && tap_rise[CK_MEAS];

  // Sync to the slow tap, measure one period, then wait two more.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_state_reg <= CMP_IDLE;
      gap_cnt_reg <= 2'd0;
    end else begin
      case (cmp_state_reg)
        CMP_IDLE: begin
          if (comp_ctrl_reg[COMP_ENABLE_BIT]) begin
            cmp_state_reg <= CMP_SYNC;
          end
        end
        CMP_SYNC: begin
          if (tap_rise[CK_SYNC]) begin
            cmp_state_reg <= CMP_MEAS;
          end
        end
        CMP_MEAS: begin
          if (tap_rise[CK_MEAS]) begin
            // Disabling only stops after a finished measurement.
            if (comp_ctrl_reg[COMP_ENABLE_BIT]) begin
              cmp_state_reg <= CMP_GAP;
              gap_cnt_reg <= MEAS_GAP_PERIODS;
            end else begin
              cmp_state_reg <= CMP_IDLE;
            end
          end
        end
        CMP_GAP: begin
          if (tap_rise[CK_MEAS]) begin
            if (gap_cnt_reg == 2'd1) begin
              cmp_state_reg <= CMP_MEAS;
            end
            gap_cnt_reg <= gap_cnt_reg - 2'd1;
          end
        end
        default: begin
          cmp_state_reg <= CMP_IDLE;
        end
      endcase
    end
  end

  // Store each result and flag changes after the first one.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      comp_result_reg <= 1'b0;
      first_done_reg <= 1'b0;
      comp_flag_reg <= 1'b0;
    end else begin
      if (meas_end) begin
        comp_result_reg <= compare_below;
        first_done_reg <= comp_ctrl_reg[COMP_ENABLE_BIT];
      end else if (cmp_state_reg == CMP_IDLE) begin
        first_done_reg <= 1'b0;
      end
      if (meas_end && first_done_reg && comp_irq_mask_reg
          && (compare_below != comp_result_reg)) begin
        comp_flag_reg <= 1'b1;
      end else if (wr_to(OFS_COMP_IRQ) && wdata[COMP_IRQ_FLAG_BIT]) begin
        comp_flag_reg <= 1'b0;
      end
    end
  end

  assign comparator_select_bit = comp_ctrl_reg[COMP_SELECT_BIT];
  assign measure_active = (cmp_state_reg == CMP_MEAS);
  assign comparator_irq = comp_flag_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Read multiplexer.

  // Pin reads are live; bit 0 reads one while the comparator owns it.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr_reg)
      OFS_INPUT_LEVEL: rd_mux[3:0] = input_pins;
      OFS_INPUT_IRQ_MASK: rd_mux[3:0] = input_irq_mask_reg;
      OFS_INPUT_IRQ_FLAGS: rd_mux[3:0] = input_flag_reg;
      OFS_INPUT_EDGE: rd_mux[3:0] = input_edge_reg;
      OFS_INPUT_DEB_OFF: rd_mux[3:0] = input_deb_off_reg;
      OFS_INPUT_PULL_OFF: rd_mux[3:0] = input_pull_off_reg;
      OFS_BIDIR_DIR: rd_mux[3:0] = bidir_dir_reg;
      OFS_BIDIR_DATA: begin
        rd_mux[3:0] = bidir_pins_in;
        if (comp_ctrl_reg[COMP_SELECT_BIT]) begin
          rd_mux[0] = 1'b1;
        end
      end
      OFS_BIDIR_PD_OFF: rd_mux[3:0] = bidir_pd_off_reg;
      OFS_BIDIR_OD: rd_mux[3:0] = bidir_od_reg;
      OFS_TAP_OPTION: rd_mux[3:0] = tap_option_reg;
      OFS_PRESC_CTRL: rd_mux[1:0] = presc_ctrl_reg;
      OFS_COMP_CTRL: rd_mux[2:0] = {comp_result_reg, comp_ctrl_reg};
      OFS_COMP_IRQ: rd_mux[1:0] = {comp_irq_mask_reg, comp_flag_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  generate
    for (gi = 0; gi < 4; gi++) begin : g_chk
      AST_PULL_EXCL: assert property (!(bidir_pullup_en[gi] && bidir_pulldown_en[gi]))
        else $error("Pull-up and pull-down both on.");
      AST_PD_COND: assert property (bidir_pulldown_en[gi] |->
        (!bidir_pd_off_reg[gi] && !bidir_od_reg[gi]))
        else $error("Pull-down on without its conditions.");
      AST_PU_COND: assert property (bidir_pullup_en[gi] |->
        (bidir_od_reg[gi] && (!bidir_dir_reg[gi] || bidir_pins_out[gi])))
        else $error("Pull-up on without its conditions.");
      AST_OD_LOW: assert property ((bidir_pins_oe[gi] && bidir_od_reg[gi])
        |-> !bidir_pins_out[gi])
        else $error("Open drain pin drives high.");
      AST_DIR_HIZ: assert property (!bidir_dir_reg[gi] |-> !bidir_pins_oe[gi])
        else $error("Input-mode pin is driven.");
      AST_FLAG_SET: assert property ((input_irq_mask_reg[gi] && active_edge[gi])
        |=> input_flag_reg[gi])
        else $error("Unmasked edge did not set its flag.");
      AST_MASKED_HOLD: assert property ((!input_irq_mask_reg[gi] && !input_flag_reg[gi])
        |=> !input_flag_reg[gi])
        else $error("Masked pin captured a request.");
      AST_W1C: assert property ((wr_to(OFS_INPUT_IRQ_FLAGS) && wdata[gi]
        && !(input_irq_mask_reg[gi] && active_edge[gi])) |=> !input_flag_reg[gi])
        else $error("Write one did not clear the flag.");
    end
  endgenerate

  AST_COMP_READ1: assert property ((rd_wait_reg && addr_reg == OFS_BIDIR_DATA
    && comp_ctrl_reg[COMP_SELECT_BIT]) |=> hrdata[0])
    else $error("Bit 0 read low while comparator selected.");
  AST_RESULT: assert property (meas_end |=> comp_result_reg == $past(compare_below))
    else $error("Result not stored at measurement end.");
  AST_GAP_SPACING: assert property (meas_end && comp_ctrl_reg[COMP_ENABLE_BIT]
    |=> cmp_state_reg == CMP_GAP && gap_cnt_reg == MEAS_GAP_PERIODS)
    else $error("Gap after a measurement is wrong.");
  AST_STOP: assert property (meas_end && !comp_ctrl_reg[COMP_ENABLE_BIT]
    |=> cmp_state_reg == CMP_IDLE)
    else $error("Sequencer kept running after disable.");
  AST_IDLE_STAYS: assert property ((cmp_state_reg == CMP_IDLE)
    && !comp_ctrl_reg[COMP_ENABLE_BIT] |=> cmp_state_reg == CMP_IDLE)
    else $error("Measurement started while disabled.");

  COV_INPUT_IRQ: cover property (input_flag_reg[0] ##1 !input_flag_reg[0]);
  COV_COMP_IRQ: cover property ($rose(comp_flag_reg));
  COV_READ_WAIT: cover property (rd_wait_reg ##1 hreadyout);
  COV_OD_PULLUP: cover property (bidir_pullup_en[3] && bidir_dir_reg[3]);

endmodule // dual_port_io
`default_nettype wire

/* File: dual_port_io_pkg.sv */
// Notes on behaviour
// - Input level register reads live pins.
// - Input masks reset masked; masked pins capture nothing.
// - Input flags reset clear; write one clears.
// - Edge select resets rising; one selects falling.
// - Debounce disable resets off; one uses direct.
// - Direction zero floats pin; one drives data.
// - Bidir data read returns pin levels.
// - Comparator selected: bit zero reads one.
// - Pull-down needs option, no disable, CMOS.
// - Pull-up needs option, open drain, high.
// - Pull-up and pull-down never together.
// - CMOS drives both; open drain only low.
// - Option bits route three taps to pins.
// - PWM enable routes counter PWM to bit3.
// - Comparator samples pin at regular tap intervals.
// - Select bit picks comparator or supply detector.
// - First result within sync plus one period.
// - Results spaced by three measurement periods.
// - After disable, finish next measurement, stop.
// - Result bit: zero above, one below.
// - Result change raises masked request, not first.
// - Debounce needs stability over two clock edges.
// - Only edges after unmasking set flags.
`default_nettype none
package dual_port_io_pkg;

  // Byte offsets of the register words on the bus.
  localparam logic [7:0] OFS_INPUT_LEVEL = 8'h00;
  localparam logic [7:0] OFS_INPUT_IRQ_MASK = 8'h04;
  localparam logic [7:0] OFS_INPUT_IRQ_FLAGS = 8'h08;
  localparam logic [7:0] OFS_INPUT_EDGE = 8'h0c;
  localparam logic [7:0] OFS_INPUT_DEB_OFF = 8'h10;
  localparam logic [7:0] OFS_INPUT_PULL_OFF = 8'h14;
  localparam logic [7:0] OFS_BIDIR_DIR = 8'h18;
  localparam logic [7:0] OFS_BIDIR_DATA = 8'h1c;
  localparam logic [7:0] OFS_BIDIR_PD_OFF = 8'h20;
  localparam logic [7:0] OFS_BIDIR_OD = 8'h24;
  localparam logic [7:0] OFS_TAP_OPTION = 8'h28;
  localparam logic [7:0] OFS_PRESC_CTRL = 8'h2c;
  localparam logic [7:0] OFS_COMP_CTRL = 8'h30;
  localparam logic [7:0] OFS_COMP_IRQ = 8'h34;

  // Reset value of every four-bit control register.
  localparam logic [3:0] RST_NIBBLE = 4'h0;

  // Tap option register fields.
  localparam int TAP_NO_INPUT_RESET = 0;
  localparam int TAP_FAST_BIT = 1;
  localparam int TAP_MID_BIT = 2;
  localparam int TAP_SLOW_BIT = 3;

  // Prescaler control fields.
  localparam int PRESC_PWM_BIT = 0;
  localparam int PRESC_DEB_SEL_BIT = 1;

  // Comparator control and request fields.
  localparam int COMP_SELECT_BIT = 0;
  localparam int COMP_ENABLE_BIT = 1;
  localparam int COMP_RESULT_BIT = 2;
  localparam int COMP_IRQ_FLAG_BIT = 0;
  localparam int COMP_IRQ_MASK_BIT = 1;

  // Prescaler tap indices used by the block.
  localparam int CK_SLOW = 1;
  localparam int CK_DEB_SLOW = 8;
  localparam int CK_SYNC = 9;
  localparam int CK_MID = 11;
  localparam int CK_DEB_FAST = 11;
  localparam int CK_MEAS = 14;
  localparam int CK_FAST = 16;

  // Measurement periods between two results, minus the measuring one.
  localparam logic [1:0] MEAS_GAP_PERIODS = 2'd2;

  // Comparator sequencer states.
  typedef enum logic [1:0] {
    CMP_IDLE,
    CMP_SYNC,
    CMP_MEAS,
    CMP_GAP
  } cmp_state_e;

endpackage
`default_nettype wire

/* File: pin_world.sv */
`timescale 1ns/10ps
`default_nettype none
module pin_world (
  // Clock.
  input wire logic clk,
  // Design side of the bidirectional pins.
  input wire logic [3:0] drv,
  input wire logic [3:0] oe,
  input wire logic [3:0] pu,
  input wire logic [3:0] pd,
  // External source driving the pins.
  input wire logic [3:0] ext,
  input wire logic [3:0] ext_en,
  // Resolved pin levels.
  output logic [3:0] lvl
);
  // Level seen on a pin that nothing drives or pulls.
  logic [3:0] wobble = 4'h5;
  //////////////////////////////////////////////////////////////////////
  // A floating pin changes every cycle, so it never looks like a stable value.
  always @(posedge clk) wobble <= ~wobble;
  // Device drive wins, then the outside source, then the pull resistors.
  assign lvl = (oe & drv) | (~oe & ext_en & ext) | (~oe & ~ext_en & (pu | (~pd & wobble)));
endmodule // pin_world
`default_nettype wire

/* File: dual_port_io_with_comparator_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module dual_port_io_with_comparator_tb;
  import dual_port_io_pkg::*;
  logic hclk, hresetn, hsel, hwrite, pwm_in, compare_below, hresp, hreadyout, sel_bit, meas, cirq;
  logic [1:0] htrans;
  logic [7:0] haddr;
  logic [31:0] hwdata, hrdata, seed, d;
  logic [15:0] cnt;
  logic [16:1] taps;
  logic [3:0] pin_in, pin_out, oe, pu, pd, ext, ext_en, ipe, iflag, ipins;
  logic [3:0] dir, dat, od, pdo, act, r4;
  logic nir;
  int n_mismatch, samples_checked;
  logic [7:0] u_offs [8] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h30, 8'h34};
  // Prescaler taps: the highest index toggles fastest.
  for (genvar i = 1; i <= 16; i++) assign taps[i] = cnt[16-i];
  dual_port_io u_dual_port_io (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ck_taps(taps), .pwm_in(pwm_in),
    .input_pins(ipins), .input_pull_enable(ipe), .input_irq_flag(iflag), .no_input_reset(nir),
    .bidir_pins_in(pin_in), .bidir_pins_out(pin_out), .bidir_pins_oe(oe), .bidir_pullup_en(pu),
    .bidir_pulldown_en(pd), .compare_below(compare_below), .comparator_select_bit(sel_bit),
    .measure_active(meas), .comparator_irq(cirq));
  pin_world u_pin_world (.clk(hclk), .drv(pin_out), .oe(oe), .pu(pu), .pd(pd), .ext(ext),
    .ext_en(ext_en), .lvl(pin_in));
  //////////////////////////////////////////////////////////////////////
  // Compares one value and counts it.
  task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One single AHB transfer; read data lands in d.
  task automatic bus(input logic [7:0] a, input logic w, input logic [3:0] wd);
    logic r;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do begin #1 r = hreadyout; @(posedge hclk); end while (!r);
    htrans <= 2'h0;
    hwdata <= {28'h0, wd};
    do begin #1 r = hreadyout; d = hrdata; @(posedge hclk); end while (!r);
  endtask
  // Next random nibble from the LFSR.
  function automatic logic [3:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[3:0];
  endfunction
  // Pull-up expected with every mask option fitted.
  function automatic logic [3:0] pu_exp(input logic [3:0] dr, dt, o);
    return o & (~dr | dt);
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  always @(posedge hclk) cnt <= cnt + 16'h1;
  // Watchdog against a hung handshake.
  initial begin
    #(20000 * 50);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {hresetn, hsel, hwrite, pwm_in, compare_below} = 5'h0;
    {haddr, htrans, hwdata, cnt, ipins, ext} = '0;
    ext_en = 4'hf;
    seed = 32'hf4f4a2c6;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    #1 chk("reset pulls", {pd == 4'hf, pu == 4'h0, ipe == 4'hf, oe == 4'h0}, 4'hf);
    @(posedge hclk);
    foreach (u_offs[i]) begin
      bus(u_offs[i], 1'b0, 4'h0);
      chk("reset value", d[3:0], 4'h0);
    end
    bus(8'h3c, 1'b1, 4'hf);
    bus(8'h3c, 1'b0, 4'h0);
    chk("unmapped", d[3:0], 4'h0);
    chk("response", {3'h0, hresp}, 4'h0);
    for (int k = 0; k < 8; k++) begin
      dir = rnd();
      dat = rnd();
      od = rnd();
      pdo = rnd();
      ipins <= rnd();
      ext <= rnd();
      ext_en <= ~dir;
      bus(OFS_BIDIR_DIR, 1'b1, dir);
      bus(OFS_BIDIR_DATA, 1'b1, dat);
      bus(OFS_BIDIR_OD, 1'b1, od);
      bus(OFS_BIDIR_PD_OFF, 1'b1, pdo);
      bus(OFS_INPUT_PULL_OFF, 1'b1, pdo);
      #1 chk("drive enable", oe, dir & ~(od & dat));
      chk("driven data", pin_out & oe, dat & oe);
      chk("pullup", pu, pu_exp(dir, dat, od));
      chk("pulldown", pd, ~pdo & ~od);
      chk("both pulls", pu & pd, 4'h0);
      chk("input pull", ipe, ~pdo);
      bus(OFS_BIDIR_DATA, 1'b0, 4'h0);
      chk("bidir read", d[3:0], pin_in);
      bus(OFS_INPUT_LEVEL, 1'b1, ~ipins);
      bus(OFS_INPUT_LEVEL, 1'b0, 4'h0);
      chk("input read", d[3:0], ipins);
    end
    // Frequency and PWM routing replace the data bits.
    bus(OFS_BIDIR_OD, 1'b1, 4'h0);
    bus(OFS_BIDIR_DIR, 1'b1, 4'hf);
    bus(OFS_TAP_OPTION, 1'b1, 4'hf);
    bus(OFS_PRESC_CTRL, 1'b1, 4'h1);
    #1 chk("no input reset", {3'h0, nir}, 4'h1);
    repeat (24) begin
      @(posedge hclk);
      r4 = rnd();
      pwm_in <= r4[0];
      #1 chk("routed", pin_out, {pwm_in, taps[1], taps[11], taps[16]});
    end
    bus(OFS_TAP_OPTION, 1'b1, 4'h0);
    bus(OFS_BIDIR_DIR, 1'b1, 4'h0);
    ext_en <= 4'hf;
    // Input port edges: rising then falling, direct path.
    bus(OFS_INPUT_DEB_OFF, 1'b1, 4'hf);
    for (int e = 0; e < 2; e++) begin
      act = e[0] ? 4'h0 : 4'hf;
      bus(OFS_INPUT_IRQ_MASK, 1'b1, 4'h0);
      bus(OFS_INPUT_EDGE, 1'b1, {4{e[0]}});
      ipins <= ~act;
      repeat (3) @(posedge hclk);
      ipins <= act;
      repeat (3) @(posedge hclk);
      bus(OFS_INPUT_IRQ_FLAGS, 1'b1, 4'hf);
      bus(OFS_INPUT_IRQ_MASK, 1'b1, 4'hf);
      chk("flag after unmask", iflag, 4'h0);
      ipins <= ~act;
      repeat (3) @(posedge hclk);
      ipins <= act;
      repeat (3) @(posedge hclk);
      bus(OFS_INPUT_IRQ_FLAGS, 1'b0, 4'h0);
      chk("flags", d[3:0], 4'hf);
      bus(OFS_INPUT_IRQ_FLAGS, 1'b1, 4'h5);
      bus(OFS_INPUT_IRQ_FLAGS, 1'b0, 4'h0);
      chk("clear ones", d[3:0], 4'ha);
    end
    // Debounced path on the fast clock: a short glitch is filtered, a held level flags.
    bus(OFS_INPUT_IRQ_MASK, 1'b1, 4'h0);
    bus(OFS_PRESC_CTRL, 1'b1, 4'h2);
    bus(OFS_INPUT_DEB_OFF, 1'b1, 4'h0);
    bus(OFS_INPUT_EDGE, 1'b1, 4'h0);
    repeat (150) @(posedge hclk);
    bus(OFS_INPUT_IRQ_FLAGS, 1'b1, 4'hf);
    bus(OFS_INPUT_IRQ_MASK, 1'b1, 4'hf);
    ipins <= 4'hf;
    repeat (3) @(posedge hclk);
    ipins <= 4'h0;
    repeat (150) @(posedge hclk);
    #1 chk("glitch filtered", iflag, 4'h0);
    ipins <= 4'hf;
    repeat (150) @(posedge hclk);
    #1 chk("debounced edge", iflag, 4'hf);
    // Comparator: results follow the level, changes raise a request.
    bus(OFS_COMP_IRQ, 1'b1, 4'h2);
    bus(OFS_COMP_CTRL, 1'b1, 4'h3);
    #1 chk("select", {3'h0, sel_bit}, 4'h1);
    bus(OFS_BIDIR_DATA, 1'b0, 4'h0);
    chk("bit0 cut off", {3'h0, d[0]}, 4'h1);
    for (int k = 0; k < 4; k++) begin
      r4 = 4'b1101 >> k;
      compare_below <= r4[0];
      repeat (300) @(posedge hclk);
      bus(OFS_COMP_CTRL, 1'b0, 4'h0);
      chk("result", {3'h0, d[2]}, {3'h0, compare_below});
      chk("comp request", {3'h0, cirq}, {3'h0, k == 1 || k == 2});
      bus(OFS_COMP_IRQ, 1'b1, 4'h3);
    end
    bus(OFS_COMP_CTRL, 1'b1, 4'h1);
    repeat (40) @(posedge hclk);
    #1 chk("stopped", {3'h0, meas}, 4'h0);
    end_of_test();
  end
endmodule // dual_port_io_with_comparator_tb
`default_nettype wire
